// ### core/chb_bus_if.sv
`timescale 1ns/1ps
module chb_bus_if (
  // Host double clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Core clocking
  input  wire logic        CLOCK_MODE_STRAP,
  input  wire logic        CORE_DOUBLE_CLOCK,
  // Host bus control
  input  wire logic        CHIP_SELECT_ENABLE,
  input  wire logic        SELECT_ACTIVE_LOW_N,
  input  wire logic        SELECT_ACTIVE_HIGH,
  input  wire logic        COMMAND_OR_DATA_SELECT_N,
  input  wire logic        WRITE_NOT_READ,
  input  wire logic        CYCLE_START_STROBE_N,
  input  wire logic        READY_N,
  // Host data bus
  input  wire logic [31:0] DATA_IN,
  output logic      [31:0] DATA_OUT,
  output logic             DATA_OE,
  // Host handshake pins
  output logic             CYCLE_DONE_OUT_N,
  output logic             CYCLE_DONE_OE,
  output logic             BUSY_N,
  output logic             BUSY_OE,
  output logic             OPERAND_TRANSFER_REQUEST,
  output logic             OPERAND_TRANSFER_OE,
  output logic             ERROR_N,
  output logic             ERROR_OE,
  // Core side
  input  wire logic        CORE_FIFO_READY,
  input  wire logic        CORE_DONE,
  input  wire logic [5:0]  CORE_EXCEPTION,
  input  wire logic        CORE_CW_LOAD,
  input  wire logic [15:0] CORE_CW_WORD,
  input  wire logic [31:0] CORE_RESULT_WORD,
  output logic             CORE_RESULT_TAKEN,
  output logic             OPCODE_VALID,
  output logic [10:0]      OPCODE_WORD,
  output logic             OPERAND_VALID,
  output logic [31:0]      OPERAND_WORD,
  output logic             CORE_ASYNC_MODE
);

  // -------------------------------------------------------------------------
  // Internal signals
  // -------------------------------------------------------------------------
  localparam int FP_WIDTH = chb_pkg::FP_PATH_W;

  logic                  ph;
  logic                  selected;
  logic                  start;
  logic                  ready_seen;
  logic                  cyc_end;
  chb_pkg::chb_kind_t    kind_in;
  chb_pkg::chb_bus_t     bus_state;
  chb_pkg::chb_bus_t     next_state;
  chb_pkg::chb_kind_t    cur_kind;
  chb_pkg::chb_kind_t    next_kind;
  chb_pkg::chb_kind_t    pend_kind;
  logic                  pend;
  logic [31:0]           word_latch;
  logic                  latch_now;
  logic [31:0]           wr_word;
  logic [31:0]           next_data;
  logic                  next_done_n;
  logic                  next_data_oe;
  logic                  core_clk_q;
  logic                  core_tick;
  logic                  done_evt;
  logic                  done_pend;
  logic                  busy;
  logic                  next_busy;
  logic                  perq;
  logic                  next_perq;
  logic                  err;
  logic                  exc_evt;
  logic [15:0]           cw;
  logic [15:0]           sw;
  logic                  show_cw;
  logic [10:0]           opc;
  logic                  opc_end;
  logic                  is_ctrl;

  // -------------------------------------------------------------------------
  // Bus clock phase and cycle detection
  // -------------------------------------------------------------------------
  // Halved host clock; second half of each bus clock samples the bus
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
    end
  end

  // Chip select and function decode
  assign selected   = CHIP_SELECT_ENABLE & ~SELECT_ACTIVE_LOW_N
                      & SELECT_ACTIVE_HIGH;
  assign start      = ph & ~CYCLE_START_STROBE_N & selected;
  assign kind_in    = chb_pkg::chb_kind_t'({COMMAND_OR_DATA_SELECT_N,
                                            WRITE_NOT_READ});
  assign ready_seen = ph & ~READY_N;
  assign cyc_end    = ready_seen & (bus_state != chb_pkg::BUS_IDLE);

  // -------------------------------------------------------------------------
  // Bus tracking state machine
  // -------------------------------------------------------------------------
  // Next state and kind, pipelined cycles restart in the first TRS
  always_comb begin
    next_state = bus_state;
    next_kind  = cur_kind;
    case (bus_state)
      chb_pkg::BUS_IDLE: begin
        if (start) begin
          next_state = chb_pkg::BUS_TRS1;
          next_kind  = kind_in;
        end
      end
      default: begin
        if (ready_seen) begin
          if (start) begin
            next_state = chb_pkg::BUS_TRS1;
            next_kind  = kind_in;
          end else if (pend) begin
            next_state = chb_pkg::BUS_TRS1;
            next_kind  = pend_kind;
          end else begin
            next_state = chb_pkg::BUS_IDLE;
          end
        end else if (ph && bus_state == chb_pkg::BUS_TRS1) begin
          next_state = chb_pkg::BUS_TRS2;
        end else if (ph) begin
          next_state = chb_pkg::BUS_TRSW;
        end
      end
    endcase
  end

  // State and held cycle kind
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_state <= chb_pkg::BUS_IDLE;
      cur_kind  <= chb_pkg::KIND_CSW_READ;
    end else begin
      bus_state <= next_state;
      cur_kind  <= next_kind;
    end
  end

  // Pipelined start seen while the current cycle still runs
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend      <= 1'b0;
      pend_kind <= chb_pkg::KIND_CSW_READ;
    end else if (start && bus_state != chb_pkg::BUS_IDLE && !ready_seen) begin
      pend      <= 1'b1;
      pend_kind <= kind_in;
    end else if (cyc_end) begin
      pend      <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Data latch and routing
  // -------------------------------------------------------------------------
  // Write data is latched at the end of the first TRS clock
  assign latch_now = ph & (bus_state == chb_pkg::BUS_TRS1) & cur_kind[0];

  always_ff @(posedge CLK) begin
    if (RST) begin
      word_latch <= chb_pkg::DATA_RST;
    end else if (latch_now) begin
      word_latch <= DATA_IN;
    end
  end

  // A zero-wait write ends on the latching edge, so use the bus word then
  assign wr_word = latch_now ? DATA_IN : word_latch;
  assign opc     = wr_word[10:0];
  assign opc_end = cyc_end & (cur_kind == chb_pkg::KIND_OPC_WRITE);
  assign is_ctrl = (opc == chb_pkg::OPC_INIT) || (opc == chb_pkg::OPC_CLEX)
                   || (opc == chb_pkg::OPC_STSW) || (opc == chb_pkg::OPC_STCW);

  // Route words to the decoder or the operand FIFO at cycle end
  always_ff @(posedge CLK) begin
    if (RST) begin
      OPCODE_VALID      <= 1'b0;
      OPCODE_WORD       <= '0;
      OPERAND_VALID     <= 1'b0;
      OPERAND_WORD      <= chb_pkg::DATA_RST;
      CORE_RESULT_TAKEN <= 1'b0;
    end else begin
      OPCODE_VALID      <= opc_end & ~is_ctrl;
      OPERAND_VALID     <= cyc_end & (cur_kind == chb_pkg::KIND_DATA_WRITE);
      CORE_RESULT_TAKEN <= cyc_end & (cur_kind == chb_pkg::KIND_DATA_READ);
      if (opc_end) begin
        OPCODE_WORD <= opc;
      end
      if (cyc_end && cur_kind == chb_pkg::KIND_DATA_WRITE) begin
        OPERAND_WORD <= wr_word;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Core clocking
  // -------------------------------------------------------------------------
  // Strap caught while reset is held; core clock rising edges give core ticks in async mode, every host clock ticks otherwise
  always_ff @(posedge CLK) begin
    if (RST) begin
      CORE_ASYNC_MODE <= ~CLOCK_MODE_STRAP;
      core_clk_q      <= 1'b0;
    end else begin
      core_clk_q      <= CORE_DOUBLE_CLOCK;
    end
  end

  assign core_tick = ~CORE_ASYNC_MODE | (CORE_DOUBLE_CLOCK & ~core_clk_q);
  assign done_evt  = core_tick & CORE_DONE;
  assign exc_evt   = core_tick & |(CORE_EXCEPTION & ~cw[5:0]);

  // -------------------------------------------------------------------------
  // Control unit: control and status words, error
  // -------------------------------------------------------------------------
  // Administrative opcodes run here; exception sets win over clears
  always_ff @(posedge CLK) begin
    if (RST) begin
      cw      <= chb_pkg::CW_RST;
      sw      <= chb_pkg::SW_RST;
      err     <= 1'b1;
      show_cw <= 1'b0;
    end else begin
      if (opc_end && opc == chb_pkg::OPC_INIT) begin
        cw <= chb_pkg::CW_RST;
      end else if (core_tick && CORE_CW_LOAD) begin
        cw <= CORE_CW_WORD;
      end
      if (opc_end && (opc == chb_pkg::OPC_INIT
                      || opc == chb_pkg::OPC_CLEX)) begin
        sw  <= chb_pkg::SW_RST | {10'h000, core_tick ? CORE_EXCEPTION
                                            : 6'h00};
        err <= exc_evt;
      end else if (core_tick) begin
        sw[chb_pkg::SW_EXC_LSB +: chb_pkg::SW_EXC_W] <=
          sw[chb_pkg::SW_EXC_LSB +: chb_pkg::SW_EXC_W] | CORE_EXCEPTION;
        err <= err | exc_evt;
      end
      sw[chb_pkg::SW_ES_BIT] <= err;
      if (opc_end && opc == chb_pkg::OPC_STCW) begin
        show_cw <= 1'b1;
      end else if (opc_end && is_ctrl) begin
        show_cw <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Busy and operand request
  // -------------------------------------------------------------------------
  // Busy releases only once the operand request is already low
  always_comb begin
    next_busy = busy;
    if (opc_end && !is_ctrl) begin
      next_busy = 1'b1;
    end else if ((done_evt || done_pend) && !perq) begin
      next_busy = 1'b0;
    end
    next_perq = next_busy & CORE_FIFO_READY & core_tick
                & ~done_evt & ~done_pend;
    if (!core_tick) begin
      next_perq = perq & next_busy & ~done_pend;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      busy      <= 1'b0;
      perq      <= 1'b0;
      done_pend <= 1'b0;
    end else begin
      busy      <= next_busy;
      perq      <= next_perq;
      done_pend <= (done_pend | (done_evt & perq)) & next_busy;
    end
  end

  // -------------------------------------------------------------------------
  // Pin drive
  // -------------------------------------------------------------------------
  // Cycle-done and data drive follow the next bus state
  always_comb begin
    next_done_n = 1'b1;
    if (next_state == chb_pkg::WRITE_DONE_STATE && next_kind[0]) begin
      next_done_n = 1'b0;
    end else if (next_state == chb_pkg::READ_DONE_STATE && !next_kind[0]) begin
      next_done_n = 1'b0;
    end
    next_data_oe = CHIP_SELECT_ENABLE && !next_kind[0]
                   && next_state != chb_pkg::BUS_IDLE;
    if (next_kind == chb_pkg::KIND_DATA_READ) begin
      next_data = CORE_RESULT_WORD;
    end else if (show_cw) begin
      next_data = {16'h0000, cw};
    end else begin
      next_data = {16'h0000, sw[15:8], err, sw[6:0]};
    end
  end

  chb_pin_reg #(.W(1), .RST_VAL(chb_pkg::DONE_N_RST), .RST_OE(1'b1))
    u_done (.clk(CLK), .rst(RST), .next_val(next_done_n),
            .next_oe(CHIP_SELECT_ENABLE),
            .pin_out(CYCLE_DONE_OUT_N), .pin_oe(CYCLE_DONE_OE));

  chb_pin_reg #(.W(1), .RST_VAL(chb_pkg::BUSY_N_RST), .RST_OE(1'b1))
    u_busy (.clk(CLK), .rst(RST), .next_val(~next_busy),
            .next_oe(CHIP_SELECT_ENABLE),
            .pin_out(BUSY_N), .pin_oe(BUSY_OE));

  chb_pin_reg #(.W(1), .RST_VAL(chb_pkg::PERQ_RST), .RST_OE(1'b1))
    u_perq (.clk(CLK), .rst(RST), .next_val(next_perq),
            .next_oe(CHIP_SELECT_ENABLE),
            .pin_out(OPERAND_TRANSFER_REQUEST),
            .pin_oe(OPERAND_TRANSFER_OE));

  chb_pin_reg #(.W(1), .RST_VAL(chb_pkg::ERROR_N_RST), .RST_OE(1'b1))
    u_err (.clk(CLK), .rst(RST), .next_val(~err),
           .next_oe(CHIP_SELECT_ENABLE),
           .pin_out(ERROR_N), .pin_oe(ERROR_OE));

  chb_pin_reg #(.W(32), .RST_VAL(chb_pkg::DATA_RST), .RST_OE(1'b0))
    u_data (.clk(CLK), .rst(RST), .next_val(next_data),
            .next_oe(next_data_oe),
            .pin_out(DATA_OUT), .pin_oe(DATA_OE));

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Outputs float one clock after enable drops
  float_off_a: assert property (!CHIP_SELECT_ENABLE |=>
      !DATA_OE && !BUSY_OE && !ERROR_OE && !CYCLE_DONE_OE
      && !OPERAND_TRANSFER_OE) else $error("outputs not floated");

  // Unselected start leaves the tracker idle
  unsel_idle_a: assert property (bus_state == chb_pkg::BUS_IDLE && ph
      && !CYCLE_START_STROBE_N && !selected |=>
      bus_state == chb_pkg::BUS_IDLE) else $error("unselected cycle taken");

  // Decoded kind held from start to ready
  kind_hold_a: assert property (bus_state == chb_pkg::BUS_IDLE && start
      ##1 (!ready_seen && !start)[*2] |-> cur_kind == $past(kind_in, 2))
      else $error("cycle kind not held");

  // Write done driven for one bus clock
  write_done_a: assert property (bus_state == chb_pkg::BUS_IDLE && start
      && kind_in[0] && CHIP_SELECT_ENABLE ##1 CHIP_SELECT_ENABLE |->
      !CYCLE_DONE_OUT_N ##1 !CYCLE_DONE_OUT_N) else $error("write done late");

  // Read done only in the second ready-sensitive clock
  read_done_a: assert property (bus_state == chb_pkg::BUS_IDLE && start
      && !kind_in[0] ##1 READY_N ##1 READY_N |->
      $past(CYCLE_DONE_OUT_N) ##1 !CYCLE_DONE_OUT_N)
      else $error("read done timing wrong");

  // Forwarded opcode always raises busy
  busy_set_a: assert property (OPCODE_VALID |-> busy
      ##1 !BUSY_N || !BUSY_OE) else $error("busy not raised");

  // Busy release preceded by low operand request
  perq_first_a: assert property ($fell(busy) |->
      !perq && !$past(perq)) else $error("request outlived busy");

  // Unmasked exception drives the error pin
  error_set_a: assert property (exc_evt && !opc_end |-> ##2
      !ERROR_N) else $error("error not asserted");

  // Data drive only in held read cycles
  data_drive_a: assert property (DATA_OE |->
      bus_state != chb_pkg::BUS_IDLE && !cur_kind[0])
      else $error("data driven outside read");

  // Bus phase alternates every host clock
  phase_step_a: assert property (!$past(RST) |-> ph != $past(ph))
      else $error("bus phase stalled");

  // Administrative opcodes never raise busy
  ctrl_busy_a: assert property (opc_end && is_ctrl && !busy |=>
      !busy) else $error("control opcode set busy");

  write_cycle_c: cover property (start && kind_in == chb_pkg::KIND_DATA_WRITE
      ##[1:8] cyc_end);
  read_cycle_c: cover property (start && kind_in == chb_pkg::KIND_CSW_READ
      ##[3:12] cyc_end);
  pipelined_c: cover property (pend ##[1:8] cyc_end);
  exception_c: cover property (busy && exc_evt);

endmodule // chb_bus_if

// ### core/chb_pin_reg.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Registered output pin with registered output enable
// ---------------------------------------------------------------------------
module chb_pin_reg #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter logic         RST_OE  = 1'b0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Next pin level and drive
  input  wire logic [W-1:0] next_val,
  input  wire logic         next_oe,
  // Pin
  output logic      [W-1:0] pin_out,
  output logic              pin_oe
);

  // Pin level and drive flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= RST_VAL;
      pin_oe  <= RST_OE;
    end else begin
      pin_out <= next_val;
      pin_oe  <= next_oe;
    end
  end

endmodule // chb_pin_reg

// ### core/chb_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the coprocessor host bus interface
// ---------------------------------------------------------------------------
package chb_pkg;

  // Bus and datapath widths
  localparam int DATA_W     = 32;
  localparam int FP_PATH_W  = 84;
  localparam int FP_SIG_W   = 68;
  localparam int FP_EXP_W   = 15;
  localparam int OPC_W      = 11;
  localparam int WORD16_W   = 16;

  // Host double clock and the halved bus clock
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CLK2_PER_BUS_CLK = 2;

  // Function decode: {command_or_data_select_n, write_not_read}
  typedef enum logic [1:0] {
    KIND_CSW_READ   = 2'b00,
    KIND_OPC_WRITE  = 2'b01,
    KIND_DATA_READ  = 2'b10,
    KIND_DATA_WRITE = 2'b11
  } chb_kind_t;

  // Bus tracking states, one per bus clock
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_TRS1 = 2'b01,
    BUS_TRS2 = 2'b10,
    BUS_TRSW = 2'b11
  } chb_bus_t;

  // Ready-sensitive state in which the cycle-done output is driven
  localparam chb_bus_t WRITE_DONE_STATE = BUS_TRS1;
  localparam chb_bus_t READ_DONE_STATE  = BUS_TRS2;

  // Opcodes executed by the control unit alone (arbitrary codes)
  localparam logic [10:0] OPC_INIT = 11'h701;
  localparam logic [10:0] OPC_CLEX = 11'h702;
  localparam logic [10:0] OPC_STSW = 11'h703;
  localparam logic [10:0] OPC_STCW = 11'h704;

  // Status word layout
  localparam int SW_EXC_LSB = 0;
  localparam int SW_EXC_W   = 6;
  localparam int SW_ES_BIT  = 7;

  // Reset values
  localparam logic [15:0] CW_RST       = 16'h003F;
  localparam logic [15:0] SW_RST       = 16'h0000;
  localparam logic        DONE_N_RST   = 1'b1;
  localparam logic        BUSY_N_RST   = 1'b1;
  localparam logic        PERQ_RST     = 1'b0;
  localparam logic        ERROR_N_RST  = 1'b0;
  localparam logic [31:0] DATA_RST     = 32'h0000_0000;

endpackage

// ### verif/chb_host_ready.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Host ready combiner, prompt or with one bus clock of wait
// ---------------------------------------------------------------------------
module chb_host_ready (
  // Clock
  input  wire logic clk,
  // Cycle-done pin of the block
  input  wire logic done_n,
  input  wire logic done_oe,
  // High adds a wait state
  input  wire logic slow,
  // Combined ready to host and block
  output logic      ready_n
);
  logic [1:0] dly_n;
  logic       pin_n;

  // Floating done pin reads high through the pull-up
  assign pin_n = done_oe ? done_n : 1'h1;

  // Delay line holds ready back by one bus clock
  always_ff @(posedge clk) begin
    dly_n <= {dly_n[0], pin_n};
  end

  // Slow selects the delayed ready, otherwise the done pin itself is the ready
  assign ready_n = slow ? dly_n[1] : pin_n;
endmodule // chb_host_ready

// ### verif/tb_chb_bus_if.sv
`timescale 1ns/1ps
module tb_chb_bus_if;
  typedef struct packed {logic [1:0] kind; logic [31:0] val;} chb_note_t;
  logic        clk, rst, strap, cclk, en, sel_n, sel, cmd_n, wnr, ads_n;
  logic        slow, fifo_rdy, core_done, cw_load, data_oe, done_n, done_oe;
  logic        busy_n, busy_oe, perq, perq_oe, err_n, err_oe, ready_n;
  logic        opc_valid, opnd_valid, async_mode, rd_now, rd_prev, taken;
  logic [4:0]  oes;
  logic [5:0]  exc, rst_pins;
  logic [10:0] opc_w;
  logic [15:0] cw_word;
  logic [31:0] din, dout, bus_d, res_word, opnd_w, v;
  logic [2:0]  bad [3];
  chb_note_t   notes [$];
  chb_note_t   note;
  int          n_fail, checks_done, n_taken, tb;

  // Shared data wire and grouped pins
  assign bus_d = data_oe ? dout : din;
  assign oes = {data_oe, done_oe, busy_oe, perq_oe, err_oe};
  assign rst_pins = {done_n, busy_n, perq, err_n, data_oe, async_mode};

  // Block and host ready logic
  chb_bus_if chb_bus_if_i (
    .CLK(clk), .RST(rst), .CLOCK_MODE_STRAP(strap),
    .CORE_DOUBLE_CLOCK(cclk), .CHIP_SELECT_ENABLE(en),
    .SELECT_ACTIVE_LOW_N(sel_n), .SELECT_ACTIVE_HIGH(sel),
    .COMMAND_OR_DATA_SELECT_N(cmd_n), .WRITE_NOT_READ(wnr),
    .CYCLE_START_STROBE_N(ads_n), .READY_N(ready_n), .DATA_IN(bus_d),
    .DATA_OUT(dout), .DATA_OE(data_oe), .CYCLE_DONE_OUT_N(done_n),
    .CYCLE_DONE_OE(done_oe), .BUSY_N(busy_n), .BUSY_OE(busy_oe),
    .OPERAND_TRANSFER_REQUEST(perq), .OPERAND_TRANSFER_OE(perq_oe),
    .ERROR_N(err_n), .ERROR_OE(err_oe), .CORE_FIFO_READY(fifo_rdy),
    .CORE_DONE(core_done), .CORE_EXCEPTION(exc), .CORE_CW_LOAD(cw_load),
    .CORE_CW_WORD(cw_word), .CORE_RESULT_WORD(res_word),
    .CORE_RESULT_TAKEN(taken), .OPCODE_VALID(opc_valid), .OPCODE_WORD(opc_w),
    .OPERAND_VALID(opnd_valid), .OPERAND_WORD(opnd_w),
    .CORE_ASYNC_MODE(async_mode));
  chb_host_ready chb_host_ready_i (
    .clk(clk), .done_n(done_n), .done_oe(done_oe), .slow(slow),
    .ready_n(ready_n));

  // Host clock and an unrelated core clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    cclk = 1'h0;
    // Half-step offset keeps core edges off host edges
    #0.5;
    forever #7 cclk = ~cclk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_bit(input logic exp, input logic got);
    cmp_word({31'h0, exp}, {31'h0, got});
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reset, then step past the edge that sets the bus phase
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'h1;
    step(20);
    rst = 1'h0;
    step(1);
    cmp_word({26'h0, 5'h18, ~s}, {26'h0, rst_pins});
  endtask

  // One host cycle, held until the sample edge that sees ready
  task automatic bus(input logic [1:0] k, input logic [31:0] wd,
                     input int n_exp);
    int n;
    n = 0;
    {cmd_n, wnr} = k;
    {en, sel_n, sel} = 3'h5;
    // Full 32-bit word, the host never narrows these cycles
    {ads_n, din} = {1'h0, wd};
    step(1);
    ads_n = 1'h1;
    do begin
      repeat (2) @(negedge clk);
      n++;
    end while (ready_n !== 1'h0 && n < 9);
    step(1);
    din = $urandom;
    step(1);
    cmp_word(32'(n_exp), 32'(n));
  endtask

  // Waits in bus clocks for busy (w=1) or operand request (w=0)
  task automatic wait_sig(input int w, input logic val);
    int n;
    n = 0;
    while ((w ? busy_n : perq) !== val && n < 50) begin
      step(2);
      n++;
    end
    cmp_bit(val, w ? busy_n : perq);
  endtask

  // Writes a random numeric opcode outside the administrative codes
  task automatic opcode;
    logic [10:0] o;
    o = 11'($urandom_range(32'h6FF, 0));
    wait_sig(1, 1'h1);
    notes.push_back({2'h0, 21'h0, o});
    bus(2'h1, {21'($urandom), o}, 1);
  endtask

  // Takes the oldest note whenever the block forwards an opcode or operand, or ends a read cycle
  always @(negedge clk) begin
    rd_now = data_oe & ~ready_n;
    if ((opc_valid | opnd_valid | (rd_now & ~rd_prev)) === 1'h1) begin
      note = notes.size() ? notes.pop_front() : '1;
      case (note.kind)
        2'h0: cmp_word(note.val, {21'h0, opc_w});
        2'h1: cmp_word(note.val, opnd_w);
        2'h2: cmp_word(note.val, bus_d);
        default: cmp_word(note.val, {16'h0, bus_d[15:0]});
      endcase
    end
    rd_prev = rd_now;
    if (taken === 1'h1) n_taken++;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #(5000 * 10);
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h4B67008E));
    {rst, strap, en, sel_n, sel, cmd_n, wnr, ads_n} = 8'hF1;
    {slow, fifo_rdy, core_done, cw_load, exc, cw_word} = '0;
    {din, res_word, n_fail, checks_done, n_taken} = '0;
    bad = '{3'h1, 3'h7, 3'h4};
    do_reset(1'h1);
    $display("reset test done");
    foreach (bad[i]) begin
      {en, sel_n, sel} = bad[i];
      ads_n = 1'h0;
      step(1);
      ads_n = 1'h1;
      repeat (7) begin
        step(1);
        cmp_bit(1'h1, ready_n);
        if (i == 0) cmp_word(32'h0, {27'h0, oes});
      end
    end
    $display("unselected test done");
    bus(2'h1, {21'h0, chb_pkg::OPC_INIT}, 1);
    step(2);
    cmp_bit(1'h1, err_n);
    cmp_bit(1'h1, busy_n);
    cw_word = 16'h0340;
    cw_load = 1'h1;
    step(1);
    {cw_load, exc} = {1'h0, 6'h01};
    step(1);
    exc = 6'h00;
    step(2);
    cmp_bit(1'h0, err_n);
    notes.push_back({2'h3, 32'h0081});
    bus(2'h0, 32'h0, 2);
    bus(2'h1, {21'h0, chb_pkg::OPC_STCW}, 1);
    notes.push_back({2'h3, 32'h0340});
    bus(2'h0, 32'h0, 2);
    slow = 1'h1;
    bus(2'h1, {21'h0, chb_pkg::OPC_CLEX}, 2);
    bus(2'h1, {21'h0, chb_pkg::OPC_STSW}, 2);
    notes.push_back({2'h3, 32'h0000});
    bus(2'h0, 32'h0, 3);
    slow = 1'h0;
    cmp_bit(1'h1, err_n);
    $display("control unit test done");
    fifo_rdy = 1'h1;
    opcode();
    cmp_bit(1'h0, busy_n);
    repeat (2) begin
      wait_sig(0, 1'h1);
      v = $urandom;
      notes.push_back({2'h1, v});
      bus(2'h3, v, 1);
    end
    res_word = $urandom;
    notes.push_back({2'h2, res_word});
    bus(2'h2, 32'h0, 2);
    core_done = 1'h1;
    step(1);
    {core_done, tb} = '0;
    // Request already low on the done edge while busy still stands
    cmp_word(32'h0, {30'h0, perq, busy_n});
    for (int k = 1; k < 10; k++) begin
      step(1);
      if (busy_n === 1'h1 && tb == 0) tb = k;
    end
    cmp_word(32'h1, 32'(tb));
    $display("numeric test done");
    opcode();
    do_reset(1'h0);
    opcode();
    wait_sig(1, 1'h0);
    core_done = 1'h1;
    wait_sig(1, 1'h1);
    core_done = 1'h0;
    step(2);
    cmp_word(32'h0, 32'(notes.size()));
    cmp_word(32'h1, 32'(n_taken));
    $display("async test done");
    complete_run();
  end
endmodule // tb_chb_bus_if
